// *** include/boot_seq_pkg.sv ***
// Package for the boot reset and clock start-up sequencer.
// Assumes a single system clock of 40 MHz; shared by the address map and sequencer modules.
package boot_seq_pkg;

  // ****************************************************
  // Timing
  // ****************************************************
  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // Crystal settling time in microseconds (plain default)
  localparam int unsigned XTAL_SETTLE_US = 1000;
  // Settling count in cycles, longest time rounds down
  localparam int unsigned XTAL_SETTLE_CYC = (XTAL_SETTLE_US * 1000000) / CLK_PERIOD_PS;
  // Width of settle counter
  localparam int unsigned SETTLE_CNT_W = 20;
  // Cycles reset output is held after release decision
  localparam int unsigned RELEASE_HOLD_CYC = 4;

  // ****************************************************
  // Address map
  // ****************************************************
  // Virtual reset address
  localparam logic [31:0] RESET_VADDR = 32'ha000_0000;
  // Untranslated uncached segment base and size
  localparam logic [31:0] SEG_UNCACHED_BASE = 32'ha000_0000;
  localparam logic [31:0] SEG_UNCACHED_SIZE = 32'h2000_0000;
  // Physical base the segment maps to
  localparam logic [31:0] PHYS_LOW_BASE = 32'h0000_0000;
  // Size of boot chip select window (64 Mbyte)
  localparam logic [31:0] BOOT_CS_SIZE = 32'h0400_0000;

  // ****************************************************
  // Clock control reset values
  // ****************************************************
  // Number of PLLs and module clocks
  localparam int unsigned NUM_PLL = 2;
  localparam int unsigned NUM_MOD = 8;
  // Divider field width, zero means undivided
  localparam int unsigned DIV_W = 4;
  localparam logic [3:0] DIV_RESET = 4'h0;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_POR    = 5'b00001,
    ST_SETTLE = 5'b00010,
    ST_SYNC   = 5'b00100,
    ST_RUN    = 5'b01000,
    ST_SPARE  = 5'b10000
  } seq_state_e;

endpackage

// *** src/sync_three.sv ***
// Three flip-flop synchroniser for a pin level.
// Assumes input is asynchronous to clk_sys; output changes once stages 2 and 3 agree.
`timescale 1ns/10ps
module sync_three #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Level in and out
  input wire logic pinIn,
  output logic levelOut
);

  // Synchroniser chain
  logic [2:0] chain_reg;
  logic [2:0] chain_next;
  // Filtered level
  logic level_reg;
  logic level_next;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    chain_next = {chain_reg[1:0], pinIn};
    level_next = level_reg;
    // Stage 1 read only by stage 2
    if (chain_reg[1] == chain_reg[2])
    begin
      level_next = chain_reg[2];
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      chain_reg <= {3{RESET_VAL}};
      level_reg <= RESET_VAL;
    end
    else
    begin
      chain_reg <= chain_next;
      level_reg <= level_next;
    end
  end

  assign levelOut = level_reg;

endmodule

// *** src/boot_addr_map.sv ***
// Boot address translation: virtual fetch address to physical, and chip select decode.
// Assumes a registered request from the sequencer on the same clock.
`timescale 1ns/10ps
module boot_addr_map (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Fetch request
  input wire logic fetchValid,
  input wire logic [31:0] fetchVaddr,
  // Translated result
  output logic [31:0] physAddr,
  output logic uncached,
  output logic bootCsSel,
  output logic mapValid
);
  import boot_seq_pkg::*;

  // Result registers
  logic [31:0] phys_reg;
  logic [31:0] phys_next;
  logic unc_reg;
  logic unc_next;
  logic cs_reg;
  logic cs_next;
  logic valid_reg;
  logic valid_next;
  // Offset inside the segment
  logic [31:0] segOffset;
  logic inSeg;

  // ****************************************************
  // Translation
  // ****************************************************
  always_comb
  begin
    segOffset = fetchVaddr - SEG_UNCACHED_BASE;
    inSeg = (fetchVaddr >= SEG_UNCACHED_BASE) && (segOffset < SEG_UNCACHED_SIZE);
    phys_next = phys_reg;
    unc_next = unc_reg;
    cs_next = cs_reg;
    valid_next = fetchValid;
    if (fetchValid)
    begin
      if (inSeg)
      begin
        phys_next = PHYS_LOW_BASE + segOffset;
        unc_next = 1'b1;
      end
      else
      begin
        phys_next = fetchVaddr;
        unc_next = 1'b0;
      end
      cs_next = inSeg && (segOffset < BOOT_CS_SIZE);
    end
  end

  // Registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      phys_reg <= 32'h0000_0000;
      unc_reg <= 1'b0;
      cs_reg <= 1'b0;
      valid_reg <= 1'b0;
    end
    else
    begin
      phys_reg <= phys_next;
      unc_reg <= unc_next;
      cs_reg <= cs_next;
      valid_reg <= valid_next;
    end
  end

  assign physAddr = phys_reg;
  assign uncached = unc_reg;
  assign bootCsSel = cs_reg;
  assign mapValid = valid_reg;

endmodule

// *** src/boot_reset_clock_startup.sv ***
// Boot reset and clock start-up sequencer: holds reset, selects clock, issues reset fetch.
// Assumes clk_sys is derived from the primary clock pin; POR and strap are asynchronous pins.
//
// Function
// - Hold chip reset while power-on reset active, except a one-cycle release if POR reasserts in the last ST_SYNC cycle
// - Primary clock pin is sole clock source
// - Strap pin selects crystal or external clock
// - Crystal mode waits for oscillator settling
// - External clock mode adds no settling delay
// - All PLLs disabled at start-up
// - All module clocks enabled and undivided
// - CPU fetches first from fixed reset address
// - Reset segment untranslated, uncached, mapped low
// - Physical zero selects boot chip select
// - Software may later change PLLs, dividers, gating
`timescale 1ns/10ps
module boot_reset_clock_startup #(
  parameter int unsigned SETTLE_CYCLES = boot_seq_pkg::XTAL_SETTLE_CYC,
  parameter int unsigned NUM_PLL_P = boot_seq_pkg::NUM_PLL,
  parameter int unsigned NUM_MOD_P = boot_seq_pkg::NUM_MOD
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pins from the board
  input wire logic porActive,
  input wire logic crystal_select_strap,
  input wire logic oscStable,
  // Software clock configuration after boot
  input wire logic cfgWrite,
  input wire logic [NUM_PLL_P-1:0] cfgPllEnable,
  input wire logic [NUM_MOD_P-1:0] cfgModGate,
  input wire logic [NUM_MOD_P*boot_seq_pkg::DIV_W-1:0] cfgModDiv,
  // Reset and clock control outputs
  output logic chipResetN,
  output logic clkSrcPrimary,
  output logic crystalMode,
  output logic [NUM_PLL_P-1:0] pllEnable,
  output logic [NUM_MOD_P-1:0] modClkEnable,
  output logic [NUM_MOD_P*boot_seq_pkg::DIV_W-1:0] modClkDiv,
  // Reset fetch towards memory
  output logic fetchStart,
  output logic [31:0] fetchVaddr,
  output logic [31:0] fetchPaddr,
  output logic fetchUncached,
  output logic boot_chip_select
);
  import boot_seq_pkg::*;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  // Synchronised levels
  logic porSync;
  logic strapSync;
  logic oscSync;

  sync_three #(.RESET_VAL(1'b1)) u_sync_por (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pinIn(porActive),
    .levelOut(porSync)
  );

  // Strap synchroniser
  sync_three #(.RESET_VAL(1'b0)) u_sync_strap (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pinIn(crystal_select_strap),
    .levelOut(strapSync)
  );

  // Oscillator ready synchroniser
  sync_three #(.RESET_VAL(1'b0)) u_sync_osc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pinIn(oscStable),
    .levelOut(oscSync)
  );

  // ****************************************************
  // Sequencer state
  // ****************************************************
  // Current and next state
  seq_state_e state_reg;
  seq_state_e state_next;
  // Settling counter
  logic [SETTLE_CNT_W-1:0] settle_reg;
  logic [SETTLE_CNT_W-1:0] settle_next;
  // Release hold counter
  logic [2:0] hold_reg;
  logic [2:0] hold_next;
  // Latched strap value
  logic xtal_reg;
  logic xtal_next;
  // Chip reset output
  logic rstn_reg;
  logic rstn_next;
  // One-cycle fetch request
  logic fetch_reg;
  logic fetch_next;
  // Settling target, cut to counter width
  logic [SETTLE_CNT_W-1:0] settleTarget;

  assign settleTarget = SETTLE_CNT_W'(SETTLE_CYCLES);

  // Next-state logic for the sequencer
  always_comb
  begin
    state_next = state_reg;
    settle_next = settle_reg;
    hold_next = hold_reg;
    xtal_next = xtal_reg;
    rstn_next = rstn_reg;
    fetch_next = 1'b0;
    case (state_reg)
      // Waiting for power-on reset to end
      ST_POR:
      begin
        rstn_next = 1'b0;
        settle_next = '0;
        hold_next = '0;
        if (!porSync)
        begin
          xtal_next = strapSync;
          state_next = strapSync ? ST_SETTLE : ST_SYNC;
        end
      end
      // Crystal settling
      ST_SETTLE:
      begin
        // count settle time, then wait stable
        if (settle_reg < settleTarget)
        begin
          settle_next = settle_reg + 1'b1;
        end
        else if (oscSync)
        begin
          state_next = ST_SYNC;
        end
        if (porSync)
        begin
          state_next = ST_POR;
        end
      end
      // Synchronous release hold
      ST_SYNC:
      begin
        // release on a clean clock edge
        if (hold_reg == 3'(RELEASE_HOLD_CYC - 1))
        begin
          rstn_next = 1'b1;
          fetch_next = 1'b1;
          state_next = ST_RUN;
        end
        else
        begin
          hold_next = hold_reg + 1'b1;
        end
        if (porSync)
        begin
          state_next = ST_POR;
        end
      end
      // Running
      ST_RUN:
      begin
        if (porSync)
        begin
          rstn_next = 1'b0;
          state_next = ST_POR;
        end
      end
      default:
      begin
        rstn_next = 1'b0;
        state_next = ST_POR;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_POR;
      settle_reg <= '0;
      hold_reg <= 3'h0;
      xtal_reg <= 1'b0;
      rstn_reg <= 1'b0;
      fetch_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      settle_reg <= settle_next;
      hold_reg <= hold_next;
      xtal_reg <= xtal_next;
      rstn_reg <= rstn_next;
      fetch_reg <= fetch_next;
    end
  end

  // ****************************************************
  // Clock control
  // ****************************************************
  // Clock configuration registers
  logic [NUM_PLL_P-1:0] pll_reg;
  logic [NUM_PLL_P-1:0] pll_next;
  logic [NUM_MOD_P-1:0] gate_reg;
  logic [NUM_MOD_P-1:0] gate_next;
  logic [NUM_MOD_P*DIV_W-1:0] div_reg;
  logic [NUM_MOD_P*DIV_W-1:0] div_next;
  logic src_reg;

  // Next values for clock configuration
  always_comb
  begin
    pll_next = pll_reg;
    gate_next = gate_reg;
    div_next = div_reg;
    if (!rstn_reg || !rstn_next)
    begin
      pll_next = '0;
      gate_next = '1;
      div_next = {NUM_MOD_P{DIV_RESET}};
    end
    else if (cfgWrite)
    begin
      pll_next = cfgPllEnable;
      gate_next = cfgModGate;
      div_next = cfgModDiv;
    end
  end

  // Clock configuration registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pll_reg <= '0;
      gate_reg <= '1;
      div_reg <= '0;
      src_reg <= 1'b1;
    end
    else
    begin
      pll_reg <= pll_next;
      gate_reg <= gate_next;
      div_reg <= div_next;
      src_reg <= 1'b1;
    end
  end

  // ****************************************************
  // Reset fetch
  // ****************************************************
  // Fetch address register
  logic [31:0] vaddr_reg;
  // Mapped results
  logic [31:0] mapPhys;
  logic mapUnc;
  logic mapCs;
  logic mapValid;

  // Reset vector register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      vaddr_reg <= 32'h0000_0000;
    end
    else
    begin
      vaddr_reg <= RESET_VADDR;
    end
  end

  // Address mapping of the reset fetch
  boot_addr_map u_map (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .fetchValid(fetch_reg),
    .fetchVaddr(vaddr_reg),
    .physAddr(mapPhys),
    .uncached(mapUnc),
    .bootCsSel(mapCs),
    .mapValid(mapValid)
  );

  // Outputs
  assign chipResetN = rstn_reg;
  assign clkSrcPrimary = src_reg;
  assign crystalMode = xtal_reg;
  assign pllEnable = pll_reg;
  assign modClkEnable = gate_reg;
  assign modClkDiv = div_reg;
  assign fetchStart = mapValid;
  assign fetchVaddr = vaddr_reg;
  assign fetchPaddr = mapPhys;
  assign fetchUncached = mapUnc;
  assign boot_chip_select = mapCs;

endmodule

// *** verif/board_model.sv ***
// Board model: supply ramp, strap tie and crystal oscillator.
// Assumes the bench drives power and mode; pins move 2 ns after clk_sys rises.
`timescale 1ns/10ps
module board_model (
  // Clock
  input wire logic clk_sys,
  // Bench controls
  input wire logic powerUp,
  input wire logic xtalFit,
  input wire logic [5:0] oscDelay,
  // Pins towards the block
  output logic porActive,
  output logic crystal_select_strap,
  output logic oscStable
);
  // Cycles since supply came up
  int upCnt = 0;

  // ****************************************************
  // Pin drive
  // ****************************************************
  initial
  begin
    porActive = 1'b1;
    crystal_select_strap = 1'b0;
    oscStable = 1'b0;
  end

  // Pins change just after the edge
  // Controls sampled at the edge, pins driven 2 ns later
  always @(posedge clk_sys)
  begin
    upCnt = powerUp ? upCnt + 1 : 0;
    porActive <= #2 (upCnt < 3);
    crystal_select_strap <= #2 xtalFit;
    // No oscillator at all with an external clock
    oscStable <= #2 xtalFit && (upCnt > oscDelay);
  end
endmodule

// *** verif/boot_reset_clock_startup_checker.sv ***
// Checker for the boot sequencer, on the top module's ports only.
// Assumes one clock domain; bound into every sequencer instance.
`timescale 1ns/10ps
module boot_seq_checker #(
  parameter int unsigned SETTLE_CYCLES = 8,
  parameter int unsigned NUM_PLL_P = 2,
  parameter int unsigned NUM_MOD_P = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Board pins
  input wire logic porActive,
  input wire logic crystal_select_strap,
  input wire logic oscStable,
  // Software configuration
  input wire logic cfgWrite,
  input wire logic [NUM_PLL_P-1:0] cfgPllEnable,
  input wire logic [NUM_MOD_P-1:0] cfgModGate,
  input wire logic [NUM_MOD_P*boot_seq_pkg::DIV_W-1:0] cfgModDiv,
  // Sequencer outputs
  input wire logic chipResetN,
  input wire logic clkSrcPrimary,
  input wire logic crystalMode,
  input wire logic [NUM_PLL_P-1:0] pllEnable,
  input wire logic [NUM_MOD_P-1:0] modClkEnable,
  input wire logic [NUM_MOD_P*boot_seq_pkg::DIV_W-1:0] modClkDiv,
  input wire logic fetchStart,
  input wire logic [31:0] fetchVaddr,
  input wire logic [31:0] fetchPaddr,
  input wire logic fetchUncached,
  input wire logic boot_chip_select
);
  import boot_seq_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ****************************************************
  // Sequences
  // ****************************************************
  sequence porEndExt; $fell(porActive) && !crystal_select_strap; endsequence
  sequence porEndXtal; $fell(porActive) && crystal_select_strap; endsequence
  sequence relRise; $rose(chipResetN); endsequence

  AST_POR_HOLD: assert property (porActive [*8] |-> !chipResetN)
    else $error("chip reset released during power-on reset");
  AST_CLK_PRIMARY: assert property (relRise |-> clkSrcPrimary)
    else $error("primary clock not selected at release");
  AST_STRAP: assert property (relRise |-> crystalMode == crystal_select_strap)
    else $error("crystal mode differs from strap");
  AST_XTAL_WAIT: assert property (porEndXtal |-> !chipResetN [*8] ##1 !chipResetN [*5])
    else $error("crystal mode released too early");
  AST_XTAL_OSC: assert property (relRise |-> !crystalMode || $past(oscStable, 6))
    else $error("release before oscillator settled");
  AST_EXT_REL: assert property (porEndExt |-> !chipResetN [*5] ##[1:8] chipResetN)
    else $error("external clock release out of window");
  AST_PLL_OFF: assert property (!chipResetN |-> pllEnable == '0)
    else $error("PLL enabled during reset");
  AST_MOD_CLK: assert property (relRise |-> &modClkEnable && modClkDiv == '0)
    else $error("module clocks not all on and undivided");
  AST_FETCH: assert property (relRise |=> fetchStart ##1 !fetchStart)
    else $error("reset fetch pulse missing");
  AST_FETCH_MAP: assert property (fetchStart |->
    fetchVaddr == 32'ha000_0000 && fetchPaddr == 32'h0 && fetchUncached)
    else $error("reset fetch mapping wrong");
  AST_BOOT_CS: assert property (fetchStart |-> boot_chip_select)
    else $error("boot chip select not decoded");
  AST_CFG: assert property (chipResetN && cfgWrite |=> pllEnable == $past(cfgPllEnable) &&
    modClkEnable == $past(cfgModGate) && modClkDiv == $past(cfgModDiv))
    else $error("clock setup write not applied");
endmodule

bind boot_reset_clock_startup boot_seq_checker #(
  .SETTLE_CYCLES(SETTLE_CYCLES),
  .NUM_PLL_P(NUM_PLL_P),
  .NUM_MOD_P(NUM_MOD_P)
) boot_seq_checker_i (.clk_sys(clk_sys), .nrst(nrst), .porActive(porActive),
  .crystal_select_strap(crystal_select_strap), .oscStable(oscStable), .cfgWrite(cfgWrite),
  .cfgPllEnable(cfgPllEnable), .cfgModGate(cfgModGate), .cfgModDiv(cfgModDiv), .chipResetN(chipResetN),
  .clkSrcPrimary(clkSrcPrimary), .crystalMode(crystalMode), .pllEnable(pllEnable), .modClkEnable(modClkEnable),
  .modClkDiv(modClkDiv), .fetchStart(fetchStart), .fetchVaddr(fetchVaddr), .fetchPaddr(fetchPaddr),
  .fetchUncached(fetchUncached), .boot_chip_select(boot_chip_select));

// *** verif/boot_reset_clock_startup_tb_top.sv ***
// Testbench for the boot sequencer with a board model on the far side.
// Assumes a short settle count; inputs move 2 ns after clk_sys rises.
`timescale 1ns/10ps
module boot_reset_clock_startup_tb_top;
  import boot_seq_pkg::*;
  localparam int SETL = 8;
  // Bench drive
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic powerUp = 1'b0;
  logic xtalFit = 1'b0;
  logic [5:0] oscDelay = 6'h0;
  logic cfgWrite = 1'b0;
  logic [NUM_PLL-1:0] cfgPllEnable = '0;
  logic [NUM_MOD-1:0] cfgModGate = '0;
  logic [NUM_MOD*DIV_W-1:0] cfgModDiv = '0;
  // Board pins and outputs
  logic porActive;
  logic crystal_select_strap;
  logic oscStable;
  logic chipResetN;
  logic clkSrcPrimary;
  logic crystalMode;
  logic [NUM_PLL-1:0] pllEnable;
  logic [NUM_MOD-1:0] modClkEnable;
  logic [NUM_MOD*DIV_W-1:0] modClkDiv;
  logic fetchStart;
  logic [31:0] fetchVaddr;
  logic [31:0] fetchPaddr;
  logic fetchUncached;
  logic boot_chip_select;
  int errTotal = 0;
  int testsRun = 0;

  always #12.5 clk_sys = ~clk_sys;

  boot_reset_clock_startup #(.SETTLE_CYCLES(SETL)) boot_reset_clock_startup_i (.clk_sys(clk_sys), .nrst(nrst),
    .porActive(porActive), .crystal_select_strap(crystal_select_strap), .oscStable(oscStable),
    .cfgWrite(cfgWrite), .cfgPllEnable(cfgPllEnable), .cfgModGate(cfgModGate), .cfgModDiv(cfgModDiv),
    .chipResetN(chipResetN), .clkSrcPrimary(clkSrcPrimary), .crystalMode(crystalMode), .pllEnable(pllEnable),
    .modClkEnable(modClkEnable), .modClkDiv(modClkDiv), .fetchStart(fetchStart), .fetchVaddr(fetchVaddr),
    .fetchPaddr(fetchPaddr), .fetchUncached(fetchUncached), .boot_chip_select(boot_chip_select));
  board_model board_model_i (.clk_sys(clk_sys), .powerUp(powerUp), .xtalFit(xtalFit),
    .oscDelay(oscDelay), .porActive(porActive), .crystal_select_strap(crystal_select_strap),
    .oscStable(oscStable));

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic endOfTest();
    $display("Checks %0d, errors %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Edges from power-up to release, allowed window
  function automatic bit relOk(input bit x, input int d, input int n);
    int lo;
    int hi;
    lo = x ? ((d + 7 > 17) ? d + 7 : 17) : 9;
    hi = x ? ((d > SETL) ? d : SETL) + 22 : 18;
    return n >= lo && n <= hi;
  endfunction

  // Power cycle in one mode, then check the boot state
  task automatic boot(input bit x, input logic [5:0] d);
    int n;
    n = 0;
    powerUp = 1'b0;
    tick(4);
    xtalFit = x;
    oscDelay = d;
    tick(2);
    powerUp = 1'b1;
    while (chipResetN !== 1'b1 && n < 200)
    begin
      tick();
      n++;
    end
    if (n >= 200)
    begin
      errTotal++;
      endOfTest();
    end
    chk("relWindow", 32'(relOk(x, d, n)), 32'h1);
    chk("crystalMode", 32'(crystalMode), 32'(x));
    chk("clkSrcPrimary", 32'(clkSrcPrimary), 32'h1);
    chk("pllEnable", 32'(pllEnable), 32'h0);
    chk("modClkEnable", 32'(modClkEnable), 32'hff);
    chk("modClkDiv", modClkDiv, 32'h0);
    tick();
    chk("fetchStart", 32'(fetchStart), 32'h1);
    chk("fetchVaddr", fetchVaddr, 32'ha000_0000);
    chk("fetchPaddr", fetchPaddr, 32'h0);
    chk("fetchUncached", 32'(fetchUncached), 32'h1);
    chk("bootCs", 32'(boot_chip_select), 32'h1);
    tick();
    chk("fetchEnd", 32'(fetchStart), 32'h0);
  endtask

  // Back-to-back random setup writes; refused while in reset
  task automatic cfg(input bit inRst, input int k);
    repeat (k)
    begin
      cfgPllEnable = NUM_PLL'($urandom);
      cfgModGate = NUM_MOD'($urandom);
      cfgModDiv = $urandom;
      cfgWrite = 1'b1;
      tick();
      chk("pllSet", 32'(pllEnable), inRst ? 32'h0 : 32'(cfgPllEnable));
      chk("gateSet", 32'(modClkEnable), inRst ? 32'hff : 32'(cfgModGate));
      chk("divSet", modClkDiv, inRst ? 32'h0 : cfgModDiv);
    end
    cfgWrite = 1'b0;
  endtask

  initial
  begin
    void'($urandom(96));
    tick(10);
    nrst = 1'b1;
    boot(1'b0, 6'h0);
    cfg(1'b0, 3);
    boot(1'b1, 6'h0);
    boot(1'b1, 6'h28);
    repeat (4)
    begin
      boot(1'($urandom_range(1)), 6'($urandom_range(63)));
      cfg(1'b0, $urandom_range(4, 1));
    end
    // Supply drop puts the chip back in reset
    powerUp = 1'b0;
    tick(10);
    chk("porHold", 32'(chipResetN), 32'h0);
    cfg(1'b1, 2);
    // Block reset while the supply is still down
    nrst = 1'b0;
    tick(3);
    chk("nrstHold", 32'(chipResetN), 32'h0);
    nrst = 1'b1;
    boot(1'b0, 6'h5);
    endOfTest();
  end
endmodule
